// file: common/adcev_cfg.svh
// Register map, field positions and reset values of the event group block
`ifndef ADCEV_CFG_SVH
`define ADCEV_CFG_SVH
`define ADCEV_OFS_EVT_SEL   8'h0c
`define ADCEV_OFS_STATUS    8'h10
`define ADCEV_OFS_CTRL      8'h14
`define ADCEV_OFS_GRP2_SEL  8'h18
`define ADCEV_OFS_RESULT0   8'h40
`define ADCEV_OFS_RESULT_HI 8'h7c
`define ADCEV_BIT_EVT_DONE  0
`define ADCEV_BIT_GRP2_DONE 1
`define ADCEV_BIT_ENABLE    0
`define ADCEV_BIT_EDGE_POL  1
`define ADCEV_BIT_SRC_LO    2
`define ADCEV_BIT_SRC_HI    3
`define ADCEV_BIT_G2_IRQ_EN 4
`define ADCEV_BIT_EV_IRQ_EN 5
`define ADCEV_RST_SEL       16'h0000
`define ADCEV_RST_CTRL      6'h00
`define ADCEV_RESP_OKAY     2'h0
`define ADCEV_RESP_SLVERR   2'h2
`endif

// file: common/adcev_pkg.sv
// Types shared by the event group block
package adcev_pkg;
   typedef enum logic [1:0] {
      adcev_idle,
      adcev_wait,
      adcev_conv
   } adcev_state_t;
endpackage

// file: common/adcev_trig_if.sv
// Trigger path between the main block and its edge detector
interface adcev_trig_if;
   logic       edge_pol;
   logic [1:0] src_sel;
   logic       trig_pulse;
   modport det (input edge_pol, input src_sel, output trig_pulse);
   modport ctl (output edge_pol, output src_sel, input trig_pulse);
endinterface

// file: rtl/adcev_conv_seq.sv
// Conversion slot timer standing in for the analog converter
module adcev_conv_seq #(
   parameter int CONV_CYCLES = 16
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   logic [7:0] cnt;
   // ----------------------------------------
   // Busy for a fixed number of cycles
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt  <= 8'h00;
         done <= 1'b0;
      end
      else
      begin
         done <= (cnt == 8'h01);
         if (start && cnt == 8'h00)
            cnt <= 8'(CONV_CYCLES);
         else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
      end
   end
   assign busy = (cnt != 8'h00);
endmodule // adcev_conv_seq

// file: rtl/adcev_sync_edge.sv
// Synchroniser and edge detector for the event sources
module adcev_sync_edge
(
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [3:0] src_in,
   adcev_trig_if.det       trig
);
   logic [3:0] meta;
   logic [3:0] sync;
   logic       prev;
   wire        cur = sync[trig.src_sel];
   // ----------------------------------------
   // Two flop sync, one pulse per edge
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= 4'h0;
         sync <= 4'h0;
         prev <= 1'b0;
      end
      else
      begin
         meta <= src_in;
         sync <= meta;
         prev <= cur;
      end
   end
   assign trig.trig_pulse = trig.edge_pol ? (cur & ~prev)
                                          : (~cur & prev);
endmodule // adcev_sync_edge

// file: rtl/adcev_top.sv
// Event group trigger, sequencing and done flags with AXI4-Lite registers
// Summary of operation
// - Group 2 done flag sets when all selected group 2 channels finish.
// - Reading a result of a selected group 2 channel clears its flag.
// - Writing the group 2 channel select clears the group 2 flag.
// - Writing 1 clears group 2 done flag; 0 leaves it.
// - Both done flags held clear while converter enable is 0.
// - Group 2 done with its interrupt enable raises an interrupt.
// - Results keep overwriting regardless of done flags.
// - Event done flag sets after all selected event channels finish.
// - Reading a result of a selected event channel clears event flag.
// - Event select write or writing 1 clears event flag; 0 no effect.
// - Event done with its interrupt enable raises an interrupt.
// - Event select holds one enable bit for each of 16 channels.
// - Sequence starts on chosen edge polarity of chosen source.
// - Idle start comes n+1 clocks after edge, n lowest channel.
// - If busy, event sequence starts right after current conversion.
// - Selected channels convert lowest number first.
// - Event select at 0x0C, read/write, resets to zero.
// - Writing zero to event select stops event conversions.
// - Rewriting selection mid-sequence continues from last converted.
// - Each result lands in result register of its channel number.
//
// Chosen here: register access over AXI4-Lite.
`include "adcev_cfg.svh"
module adcev_top #(
   parameter int NCH         = 16,
   parameter int CONV_CYCLES = 16
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        event_input_pin,
   input  wire logic [2:0]  evt_aux_src,
   input  wire logic        other_conv_busy,
   input  wire logic        grp2_all_done,
   input  wire logic [11:0] conv_data,
   output logic             grp2_irq,
   output logic             evt_irq,
   output logic             evt_conv_active
);
   // ----------------------------------------
   // Registers and state
   // ----------------------------------------
   logic [NCH-1:0]   evt_chan_select;
   logic [NCH-1:0]   grp2_chan_select;
   logic [5:0]       ctrl;
   logic             grp2_done_flag;
   logic             evt_done_flag;
   logic [11:0]      conv_result_reg [NCH];
   logic [NCH-1:0]   pending;
   logic [3:0]       cur_ch;
   logic [4:0]       dly;
   adcev_pkg::adcev_state_t state;
   logic [7:0]       aw_addr;
   logic [31:0]      w_data;
   logic             aw_held;
   logic             w_held;
   adcev_trig_if     trig ();
   logic             conv_start;
   logic             conv_busy;
   logic             conv_done;

   wire converter_enable  = ctrl[`ADCEV_BIT_ENABLE];
   wire grp2_done_irq_en  = ctrl[`ADCEV_BIT_G2_IRQ_EN];
   wire evt_done_irq_en   = ctrl[`ADCEV_BIT_EV_IRQ_EN];
   assign trig.edge_pol   = ctrl[`ADCEV_BIT_EDGE_POL];
   assign trig.src_sel    = ctrl[`ADCEV_BIT_SRC_HI:`ADCEV_BIT_SRC_LO];

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   adcev_sync_edge u_sync
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .src_in  ({evt_aux_src, event_input_pin}),
      .trig    (trig)
   );

   adcev_conv_seq #(.CONV_CYCLES(CONV_CYCLES)) u_conv
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (conv_start),
      .busy    (conv_busy),
      .done    (conv_done)
   );

   // ----------------------------------------
   // Write channel decode
   // ----------------------------------------
   wire wr_go   = aw_held && w_held && !s_axi_bvalid;
   wire wr_sel  = wr_go && aw_addr == `ADCEV_OFS_EVT_SEL;
   wire wr_stat = wr_go && aw_addr == `ADCEV_OFS_STATUS;
   wire wr_ctrl = wr_go && aw_addr == `ADCEV_OFS_CTRL;
   wire wr_g2   = wr_go && aw_addr == `ADCEV_OFS_GRP2_SEL;
   wire wr_ok   = wr_sel | wr_stat | wr_ctrl | wr_g2;
   wire lo_en   = s_axi_wstrb[0];
   wire [15:0] wsel_val = {w_data[15:8] & {8{s_axi_wstrb[1]}},
                           w_data[7:0] & {8{lo_en}}};

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ADCEV_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (wr_go)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `ADCEV_RESP_OKAY : `ADCEV_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Read channel decode
   // ----------------------------------------
   wire       rd_go   = s_axi_arvalid && s_axi_arready;
   wire [7:0] ra      = {s_axi_araddr[7:2], 2'b00};
   wire       rd_res  = ra >= `ADCEV_OFS_RESULT0 &&
                        ra <= `ADCEV_OFS_RESULT_HI;
   wire [3:0] rd_ch   = ra[5:2];
   wire       rd_evt  = rd_go && rd_res && evt_chan_select[rd_ch];
   wire       rd_g2   = rd_go && rd_res && grp2_chan_select[rd_ch];
   wire [15:0] stat_v = {14'h0, grp2_done_flag, evt_done_flag};
   wire [31:0] rd_val =
      ra == `ADCEV_OFS_EVT_SEL  ? {16'h0, evt_chan_select} :
      ra == `ADCEV_OFS_STATUS   ? {16'h0, stat_v} :
      ra == `ADCEV_OFS_CTRL     ? {26'h0, ctrl} :
      ra == `ADCEV_OFS_GRP2_SEL ? {16'h0, grp2_chan_select} :
      rd_res                    ? {20'h0, conv_result_reg[rd_ch]} :
                                  32'h0;
   wire rd_ok = rd_res || ra == `ADCEV_OFS_EVT_SEL ||
                ra == `ADCEV_OFS_STATUS || ra == `ADCEV_OFS_CTRL ||
                ra == `ADCEV_OFS_GRP2_SEL;

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= `ADCEV_RESP_OKAY;
      end
      else if (rd_go)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_ok ? `ADCEV_RESP_OKAY : `ADCEV_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         evt_chan_select  <= `ADCEV_RST_SEL;
         grp2_chan_select <= `ADCEV_RST_SEL;
         ctrl             <= `ADCEV_RST_CTRL;
      end
      else
      begin
         if (wr_sel)
            evt_chan_select <= wsel_val;
         if (wr_g2)
            grp2_chan_select <= wsel_val;
         if (wr_ctrl && lo_en)
            ctrl <= w_data[5:0];
      end
   end

   // ----------------------------------------
   // Event sequencer
   // ----------------------------------------
   logic [3:0] low_ch;
   logic       low_any;
   always_comb
   begin
      low_ch  = 4'h0;
      low_any = 1'b0;
      for (int i = NCH - 1; i >= 0; i--)
      begin
         if (pending[i])
         begin
            low_ch  = 4'(i);
            low_any = 1'b1;
         end
      end
   end

   wire [NCH-1:0] above_last = ~((NCH'(2) << cur_ch) - NCH'(1));
   wire trig_ok = trig.trig_pulse && converter_enable &&
                  state == adcev_pkg::adcev_idle &&
                  evt_chan_select != '0;
   assign conv_start = state == adcev_pkg::adcev_wait && dly == 5'h00 &&
                       !other_conv_busy && !conv_busy && low_any;
   assign evt_conv_active = state != adcev_pkg::adcev_idle;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !converter_enable)
      begin
         state   <= adcev_pkg::adcev_idle;
         pending <= '0;
         cur_ch  <= 4'h0;
         dly     <= 5'h00;
      end
      else if (wr_sel && state != adcev_pkg::adcev_idle)
      begin
         pending <= wsel_val & above_last;
         if ((wsel_val & above_last) == '0)
            state <= adcev_pkg::adcev_idle;
      end
      else
      begin
         unique case (state)
            adcev_pkg::adcev_idle:
               if (trig_ok)
               begin
                  pending <= evt_chan_select;
                  dly     <= 5'({1'b0, low_of(evt_chan_select)});
                  state   <= adcev_pkg::adcev_wait;
               end
            adcev_pkg::adcev_wait:
               if (dly != 5'h00)
                  dly <= dly - 5'h01;
               else if (!low_any)
                  state <= adcev_pkg::adcev_idle;
               else if (conv_start)
               begin
                  cur_ch  <= low_ch;
                  pending[low_ch] <= 1'b0;
                  state   <= adcev_pkg::adcev_conv;
               end
            adcev_pkg::adcev_conv:
               if (conv_done)
                  state <= low_any ? adcev_pkg::adcev_wait
                                   : adcev_pkg::adcev_idle;
         endcase
      end
   end

   function automatic logic [3:0] low_of(input logic [NCH-1:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = NCH - 1; i >= 0; i--)
         if (v[i])
            r = 4'(i);
      return r;
   endfunction

   wire evt_seq_end = state == adcev_pkg::adcev_conv && conv_done &&
                      !low_any;

   // ----------------------------------------
   // Results, overwritten freely
   // ----------------------------------------
   always_ff @(posedge aclk)
   begin
      if (state == adcev_pkg::adcev_conv && conv_done)
         conv_result_reg[cur_ch] <= conv_data;
   end

   // ----------------------------------------
   // Done flags, set wins over clear
   // ----------------------------------------
   wire w1c_ok  = wr_stat && lo_en;
   wire clr_g2  = rd_g2 || wr_g2 ||
                  (w1c_ok && w_data[`ADCEV_BIT_GRP2_DONE]);
   wire clr_ev  = rd_evt || wr_sel ||
                  (w1c_ok && w_data[`ADCEV_BIT_EVT_DONE]);

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !converter_enable)
      begin
         grp2_done_flag <= 1'b0;
         evt_done_flag  <= 1'b0;
      end
      else
      begin
         if (grp2_all_done)
            grp2_done_flag <= 1'b1;
         else if (clr_g2)
            grp2_done_flag <= 1'b0;
         if (evt_seq_end)
            evt_done_flag <= 1'b1;
         else if (clr_ev)
            evt_done_flag <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         grp2_irq <= 1'b0;
         evt_irq  <= 1'b0;
      end
      else
      begin
         grp2_irq <= grp2_done_flag && grp2_done_irq_en;
         evt_irq  <= evt_done_flag && evt_done_irq_en;
      end
   end
endmodule // adcev_top

// file: verification/adcev_properties.sv
// Port checker for the event group block
`include "adcev_cfg.svh"
module adcev_properties #(
   parameter int NCH         = 16,
   parameter int CONV_CYCLES = 16
)
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        grp2_irq,
   input wire logic        evt_irq,
   input wire logic        evt_conv_active
);
   wire logic w_hs;
   wire logic ar_hs;
   assign w_hs = s_axi_wvalid && s_axi_wready;
   assign ar_hs = s_axi_arvalid && s_axi_arready;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ----------------
   // Assertions
   // ----------------
   a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=>
      !s_axi_bvalid && !s_axi_rvalid && !grp2_irq && !evt_irq)
      else $error("outputs active after reset");
   a_wr_block: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while response pending");
   a_rd_answer: assert property (ar_hs |=> s_axi_rvalid)
      else $error("read answer late");
   a_wr_answer: assert property ($rose(s_axi_bvalid) |->
      $past(w_hs) || $past(w_hs, 2))
      else $error("write answer without write data");
   a_rd_slverr: assert property (ar_hs && s_axi_araddr >= 8'h80 |=>
      s_axi_rresp == `ADCEV_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   a_sel_read: assert property (
      ar_hs && s_axi_araddr == `ADCEV_OFS_EVT_SEL |=>
      s_axi_rresp == `ADCEV_RESP_OKAY && s_axi_rdata[31:16] == 16'h0)
      else $error("select read wrong");
   a_disable_clr: assert property (
      w_hs && s_axi_awaddr == `ADCEV_OFS_CTRL && !s_axi_wdata[0] |->
      ##[1:4] (!evt_irq && !grp2_irq))
      else $error("irq stays with converter disabled");
   c_evt_irq: cover property ($rose(evt_irq));
   c_grp2_irq: cover property ($rose(grp2_irq));
   c_slverr: cover property (s_axi_rvalid && s_axi_rresp[1]);
endmodule // adcev_properties

bind adcev_top adcev_properties #(.NCH(NCH), .CONV_CYCLES(CONV_CYCLES))
   adcev_properties_inst (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .grp2_irq(grp2_irq), .evt_irq(evt_irq),
   .evt_conv_active(evt_conv_active));

// file: verification/adcev_top_tb.sv
// Register level testbench for the event group block
`include "adcev_cfg.svh"
module adcev_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, awready, wready, bvalid, arready, rvalid;
   logic        awvalid, wvalid, bready, arvalid, rready, g2_done, pol;
   logic        grp2_irq, evt_irq, evt_act, oth;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd_val, r1, r3, r11;
   logic [1:0]  bresp, rresp, rd_resp;
   logic [3:0]  srcs;
   logic [11:0] conv_data = 12'h000;
   int          mismatches, n_checks;

   always #12.5 aclk = ~aclk;
   always @(posedge aclk) conv_data <= conv_data + 12'h001;

   adcev_top #(.CONV_CYCLES(4)) adcev_top_inst (.aclk(aclk),
      .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .event_input_pin(srcs[0]),
      .evt_aux_src(srcs[3:1]), .other_conv_busy(oth),
      .grp2_all_done(g2_done), .conv_data(conv_data),
      .grp2_irq(grp2_irq), .evt_irq(evt_irq), .evt_conv_active(evt_act));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_p;
      logic w_p;
      aw_p = 1'b1;
      w_p = 1'b1;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (aw_p || w_p)
      begin
         @(negedge aclk);
         if (awready)
            aw_p = 1'b0;
         if (wready)
            w_p = 1'b0;
         @(posedge aclk);
         awvalid <= aw_p;
         wvalid <= w_p;
      end
      do
         @(negedge aclk);
      while (bvalid !== 1'b1);
      @(posedge aclk);
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
         @(negedge aclk);
      while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do
         @(negedge aclk);
      while (rvalid !== 1'b1);
      rd_val = rdata;
      rd_resp = rresp;
      @(posedge aclk);
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_val, exp);
   endtask

   task automatic wait_evt();
      int n;
      n = 0;
      while (evt_irq !== 1'b1 && n < 400)
      begin
         @(negedge aclk);
         n++;
      end
      chk({31'h0, evt_irq}, 32'h1);
      @(posedge aclk);
   endtask

   task automatic pulse_g2();
      g2_done <= 1'b1;
      @(posedge aclk);
      g2_done <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      wrap_up();
   end

   // ----------------
   // Test sequence
   // ----------------
   initial
   begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
      {g2_done, oth, awaddr, araddr, wdata} = 50'h0;
      srcs = 4'hf;
      mismatches = 0;
      n_checks = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rchk(`ADCEV_OFS_EVT_SEL, 32'h0);
      wr(`ADCEV_OFS_EVT_SEL, 32'hffffffff);
      rchk(`ADCEV_OFS_EVT_SEL, 32'h0000ffff);
      rd(8'h84);
      chk({30'h0, rd_resp}, {30'h0, `ADCEV_RESP_SLVERR});
      chk(rd_val, 32'h0);
      wr(`ADCEV_OFS_EVT_SEL, 32'h0000080a);
      for (int s = 0; s < 4; s++)
      begin
         pol = s[0];
         srcs <= {4{~pol}};
         repeat (8) @(posedge aclk);
         wr(`ADCEV_OFS_CTRL, {26'h0, 2'b11, s[1:0], pol, 1'b1});
         srcs <= {4{pol}} ^ (4'h1 << s);
         repeat (8) @(posedge aclk);
         chk({31'h0, evt_act}, 32'h0);
         srcs <= {4{pol}};
         wait_evt();
         rchk(`ADCEV_OFS_STATUS, 32'h1);
         case (s)
            0:
            begin
               wr(`ADCEV_OFS_STATUS, 32'h0);
               rchk(`ADCEV_OFS_STATUS, 32'h1);
               wr(`ADCEV_OFS_STATUS, 32'h1);
            end
            1:
            begin
               rd(8'h44);
               r1 = rd_val;
               rd(8'h4c);
               r3 = rd_val;
               rd(8'h6c);
               r11 = rd_val;
               chk({31'h0, r1 < r3 && r3 < r11}, 32'h1);
            end
            2:
               wr(`ADCEV_OFS_EVT_SEL, 32'h0000080a);
            default:
               wr(`ADCEV_OFS_CTRL, 32'h0);
         endcase
         rchk(`ADCEV_OFS_STATUS, 32'h0);
      end
      wr(`ADCEV_OFS_CTRL, 32'h33);
      wr(`ADCEV_OFS_EVT_SEL, 32'h0);
      srcs <= 4'h0;
      repeat (8) @(posedge aclk);
      srcs <= 4'h1;
      repeat (40) @(posedge aclk);
      chk({31'h0, evt_act}, 32'h0);
      rchk(`ADCEV_OFS_STATUS, 32'h0);
      wr(`ADCEV_OFS_EVT_SEL, 32'h8);
      oth <= 1'b1;
      srcs <= 4'h0;
      repeat (8) @(posedge aclk);
      srcs <= 4'h1;
      repeat (40) @(posedge aclk);
      chk({31'h0, evt_act}, 32'h1);
      rchk(`ADCEV_OFS_STATUS, 32'h0);
      oth <= 1'b0;
      wait_evt();
      wr(`ADCEV_OFS_STATUS, 32'h1);
      wr(`ADCEV_OFS_GRP2_SEL, 32'h20);
      pulse_g2();
      chk({31'h0, grp2_irq}, 32'h1);
      rchk(`ADCEV_OFS_STATUS, 32'h2);
      wr(`ADCEV_OFS_STATUS, 32'h1);
      rchk(`ADCEV_OFS_STATUS, 32'h2);
      wr(`ADCEV_OFS_STATUS, 32'h2);
      rchk(`ADCEV_OFS_STATUS, 32'h0);
      pulse_g2();
      wr(`ADCEV_OFS_GRP2_SEL, 32'h20);
      rchk(`ADCEV_OFS_STATUS, 32'h0);
      pulse_g2();
      rd(8'h48);
      rchk(`ADCEV_OFS_STATUS, 32'h2);
      rd(8'h54);
      rchk(`ADCEV_OFS_STATUS, 32'h0);
      pulse_g2();
      wr(`ADCEV_OFS_CTRL, 32'h32);
      rchk(`ADCEV_OFS_STATUS, 32'h0);
      chk({31'h0, grp2_irq}, 32'h0);
      wrap_up();
   end
endmodule // adcev_top_tb
